// >>> rtl/cpms_ctrl.v
// Control pin mode select: feature enables, pin routing and reset handling
`timescale 1ns/1ns
`default_nettype none
`include "cpms_regs.vh"

module cpms_ctrl #(
    parameter NFEAT = `CPMS_NFEAT,
    parameter NSTAT = 4
) (
    input wire clk,
    input wire rstn,
    input wire processing_enable_pin,
    input wire test_host_sel_pin,
    input wire shared_select_pin,
    input wire shared_clock_pin,
    input wire shared_serial_in_pin,
    input wire [NFEAT-1:0] processing_disable_reg,
    input wire host_serial_out,
    input wire host_serial_out_en,
    input wire scan_serial_out,
    input wire scan_serial_out_en,
    input wire [NSTAT-1:0] status_in,
    input wire data_error_in,
    output reg [NFEAT-1:0] feature_en,
    output reg low_latency_mode,
    output reg test_mode,
    output reg host_cs_active,
    output reg host_sclk,
    output reg host_sdin,
    output reg scan_tms,
    output reg scan_tck,
    output reg scan_tdi,
    output reg scan_seq_reset,
    output reg shared_serial_out_pin,
    output reg shared_serial_out_oe_n,
    output reg outputs_hiz,
    output reg [NSTAT-1:0] status_out,
    output reg data_error_out
);

    // ****************************************
    // Synchronisers
    // ****************************************
    reg pen_s1_r;
    reg pen_s2_r;
    reg sel_s1_r;
    reg sel_s2_r;
    reg rst_done_r;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pen_s1_r <= 1'b0;
            pen_s2_r <= 1'b0;
            sel_s1_r <= `CPMS_MODE_HOST;
            sel_s2_r <= `CPMS_MODE_HOST;
        end
        else
        begin
            pen_s1_r <= processing_enable_pin;
            pen_s2_r <= pen_s1_r;
            sel_s1_r <= test_host_sel_pin;
            sel_s2_r <= sel_s1_r;
        end
    end

    // scan_seq_reset, outputs_hiz and the status capture hold their reset behaviour for one edge after release
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_done_r <= 1'b0;
        else
            rst_done_r <= 1'b1;
    end

    // ****************************************
    // Feature enables
    // ****************************************
    wire [NFEAT-1:0] feature_en_nxt;
    wire low_latency_nxt;

    // low pin gives low latency bypass
    assign low_latency_nxt = ~pen_s2_r;

    // every feature follows the synced enable unless its disable bit is set
    genvar g;
    generate
        for (g = 0; g < NFEAT; g = g + 1)
        begin : g_feat
            // A disable bit only matters while the group enable is high
            assign feature_en_nxt[g] = pen_s2_r & ~processing_disable_reg[g];
        end
    endgenerate

    // ****************************************
    // Pin routing
    // ****************************************
    reg host_cs_active_nxt;
    reg host_sclk_nxt;
    reg host_sdin_nxt;
    reg scan_tms_nxt;
    reg scan_tck_nxt;
    reg scan_tdi_nxt;
    reg serial_out_nxt;
    reg serial_out_oe_n_nxt;

    // Only the synced select steers the pins, so a glitch on the raw
    // select pin can never hand the shared pins to both sides at once.
    always @*
    begin
        host_cs_active_nxt = 1'b0;
        host_sclk_nxt = 1'b0;
        host_sdin_nxt = 1'b0;
        scan_tms_nxt = 1'b0;
        scan_tck_nxt = 1'b0;
        scan_tdi_nxt = 1'b0;
        serial_out_nxt = host_serial_out;
        serial_out_oe_n_nxt = ~host_serial_out_en;
        if (sel_s2_r)
        begin
            scan_tms_nxt = shared_select_pin;
            scan_tck_nxt = shared_clock_pin;
            scan_tdi_nxt = shared_serial_in_pin;
            serial_out_nxt = scan_serial_out;
            serial_out_oe_n_nxt = ~scan_serial_out_en;
        end
        else
        begin
            host_cs_active_nxt = ~shared_select_pin;
            host_sclk_nxt = shared_clock_pin;
            host_sdin_nxt = shared_serial_in_pin;
            serial_out_nxt = host_serial_out;
            serial_out_oe_n_nxt = ~host_serial_out_en;
        end
    end

    // ****************************************
    // Output registers
    // ****************************************
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            feature_en <= `CPMS_FEAT_RST;
            low_latency_mode <= 1'b0;
            test_mode <= `CPMS_MODE_HOST;
            host_cs_active <= 1'b0;
            host_sclk <= 1'b0;
            host_sdin <= 1'b0;
            scan_tms <= 1'b0;
            scan_tck <= 1'b0;
            scan_tdi <= 1'b0;
            scan_seq_reset <= 1'b1;
            shared_serial_out_pin <= 1'b0;
            shared_serial_out_oe_n <= 1'b1;
            outputs_hiz <= 1'b1;
        end
        else
        begin
            feature_en <= feature_en_nxt;
            low_latency_mode <= low_latency_nxt;
            test_mode <= sel_s2_r;

            // scan sequence leaves reset on the second edge after release
            scan_seq_reset <= ~rst_done_r;
            outputs_hiz <= ~rst_done_r;

            host_cs_active <= host_cs_active_nxt;
            host_sclk <= host_sclk_nxt;
            host_sdin <= host_sdin_nxt;

            scan_tms <= scan_tms_nxt;
            scan_tck <= scan_tck_nxt;
            scan_tdi <= scan_tdi_nxt;

            shared_serial_out_pin <= serial_out_nxt;
            shared_serial_out_oe_n <= serial_out_oe_n_nxt;
        end
    end

    // ****************************************
    // Status and error flag
    // ****************************************
    // status and error flag keep last state through reset
    // Plain clocked register, so reset leaves the held value untouched.
    always @(posedge clk)
    begin
        if (rstn && rst_done_r)
        begin
            status_out <= status_in;
            data_error_out <= data_error_in;
        end
    end

endmodule // cpms_ctrl
`default_nettype wire

// >>> rtl/cpms_regs.vh
// Constants for the control pin and mode select block
`ifndef CPMS_REGS_VH
`define CPMS_REGS_VH
// Feature bit positions in the processing-disable word and the enable vector
`define CPMS_FEAT_REMAP 0
`define CPMS_FEAT_EDP_CRC 1
`define CPMS_FEAT_ANC_CSUM 2
`define CPMS_FEAT_TRW 3
`define CPMS_FEAT_EDP_FLAG 4
`define CPMS_NFEAT 5
// Reset values
`define CPMS_DIS_RST 5'h00
`define CPMS_FEAT_RST 5'h00
`define CPMS_STAT_RST 4'h0
// Pin role after reset: host interface
`define CPMS_MODE_HOST 1'b0
`define CPMS_MODE_TEST 1'b1
`endif

// >>> testbench/cpms_checker.sv
// Assertion checker for the control pin mode select block
`timescale 1ns/1ns
`default_nettype none
module cpms_checker #(parameter NFEAT = 5, parameter NSTAT = 4) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic processing_enable_pin,
    input wire logic test_host_sel_pin,
    input wire logic shared_select_pin,
    input wire logic [NFEAT-1:0] processing_disable_reg,
    input wire logic [NFEAT-1:0] feature_en,
    input wire logic low_latency_mode,
    input wire logic test_mode,
    input wire logic host_cs_active,
    input wire logic scan_tms,
    input wire logic scan_seq_reset,
    input wire logic shared_serial_out_oe_n,
    input wire logic outputs_hiz,
    input wire logic [NSTAT-1:0] status_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Synchronisers have refilled since the last reset
    sequence s_up; $past(rstn, 5); endsequence
    AST_FEAT: assert property (s_up ##0 processing_enable_pin [*3]
        |=> feature_en == ~$past(processing_disable_reg)) else $error("enables wrong");
    AST_LOWLAT: assert property (s_up ##0 !processing_enable_pin [*3]
        |=> low_latency_mode && feature_en == 0) else $error("not bypassed");
    AST_TEST: assert property (s_up ##0 test_host_sel_pin [*4]
        |=> test_mode && !host_cs_active && scan_tms == $past(shared_select_pin))
        else $error("scan routing wrong");
    AST_HOST: assert property (s_up ##0 !test_host_sel_pin [*4]
        |=> !test_mode && !scan_tms && host_cs_active == !$past(shared_select_pin))
        else $error("host routing wrong");
    AST_RST: assert property (disable iff (1'b0) !rstn ##1 !rstn
        |-> scan_seq_reset && outputs_hiz && shared_serial_out_oe_n && feature_en == 0)
        else $error("reset state wrong");
    AST_HOLD: assert property (disable iff (1'b0) $past(rstn, 3) && !rstn
        |=> $stable(status_out)) else $error("status not held");
    AST_REL: assert property ($rose(rstn)
        |-> scan_seq_reset [*2] ##1 !scan_seq_reset && !outputs_hiz) else $error("release wrong");
    AST_SYNC: assert property (s_up ##0 $stable(processing_enable_pin) [*3]
        ##1 $changed(processing_enable_pin)
        |=> $stable(low_latency_mode) [*2] ##1 $changed(low_latency_mode)) else $error("sync wrong");
endmodule // cpms_checker
`default_nettype wire

// >>> testbench/cpms_host.sv
// Host controller or scan tester driving the static control pins
`timescale 1ns/1ns
`default_nettype none
module cpms_host (
    input wire logic clk,
    output var logic pen,
    output var logic mode,
    output var logic sel,
    output var logic sck,
    output var logic sdi
);
    initial {pen, mode, sel, sck, sdi} = 5'h14;
    // pins move off the sampling edge
    task automatic put(input logic [4:0] v);
        @(negedge clk);
        {pen, mode, sel, sck, sdi} = v;
    endtask
endmodule // cpms_host
`default_nettype wire

// >>> testbench/tb_control_pin_mode_select.sv
// Testbench for the control pin mode select block
`timescale 1ns/1ns
`default_nettype none
module tb_control_pin_mode_select;
    logic clk = 0, rstn = 0, hso = 1, hoe = 1, sso = 0, soe = 1, derr = 1;
    logic [4:0] dis = 5'h00, fe;
    logic [3:0] st = 4'h5, so;
    logic pen, mode, sel, sck, sdi, ll, tm, hcs, hck, hdi, tms, tck, tdi, sr, po, po_oe_n, hz, deo;
    int n_errors = 0, tests_run = 0, cyc = 0, i;
    always #50 clk = ~clk;
    cpms_host host (.clk(clk), .pen(pen), .mode(mode), .sel(sel), .sck(sck), .sdi(sdi));
    cpms_ctrl dut (.clk(clk), .rstn(rstn), .processing_enable_pin(pen), .test_host_sel_pin(mode),
        .shared_select_pin(sel), .shared_clock_pin(sck), .shared_serial_in_pin(sdi),
        .processing_disable_reg(dis), .host_serial_out(hso), .host_serial_out_en(hoe),
        .scan_serial_out(sso), .scan_serial_out_en(soe), .status_in(st), .data_error_in(derr),
        .feature_en(fe), .low_latency_mode(ll), .test_mode(tm), .host_cs_active(hcs),
        .host_sclk(hck), .host_sdin(hdi), .scan_tms(tms), .scan_tck(tck), .scan_tdi(tdi),
        .scan_seq_reset(sr), .shared_serial_out_pin(po), .shared_serial_out_oe_n(po_oe_n),
        .outputs_hiz(hz), .status_out(so), .data_error_out(deo));
    task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // A hang of the main sequence counts as a failure
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            end_of_test;
        end
    end
    initial
    begin
        repeat (8) @(negedge clk);
        rstn = 1;
        repeat (5) @(negedge clk);
        // Last pass clears the disable word, all features on
        for (i = 0; i < 6; i++)
        begin
            dis = 5'h01 << i;
            repeat (2) @(negedge clk);
            chk("feature_en", ~(5'h01 << i), fe);
        end
        host.put(5'h0F);
        repeat (4) @(negedge clk);
        chk("bypass", 5'h10, {ll, fe[3:0]});
        chk("scan pins", 5'h1E, {tm, tms, tck, tdi, hcs});
        chk("scan out", 5'h00, {po, po_oe_n});
        host.put(5'h13);
        repeat (4) @(negedge clk);
        chk("host pins", 5'h0E, {tm, hcs, hck, hdi, tck});
        chk("host out", 5'h02, {po, po_oe_n});
        rstn = 0;
        st = 4'hC;
        derr = 0;
        repeat (3) @(negedge clk);
        chk("status hold", 5'h15, {deo, so});
        chk("reset pins", 5'h1C, {sr, hz, po_oe_n, fe[0], tm});
        rstn = 1;
        repeat (3) @(negedge clk);
        chk("release", 5'h00, {sr, hz});
        end_of_test;
    end
endmodule // tb_control_pin_mode_select
bind cpms_ctrl cpms_checker #(.NFEAT(NFEAT), .NSTAT(NSTAT)) chk_i (.*);
`default_nettype wire
